//--- logic/wbm_regs.sv
/*
 Watchdog control and bus control register bank with effective transceiver modes.
 Assumes access requests arrive as one-cycle strobes from the SPI frame decoder, and that
 soft reset, restart entry and the system mode come from the mode controller.
*/
`timescale 1ns/1ns
module wbm_regs (
    input  wire logic                     clock,            // 20 MHz system clock
    input  wire logic                     reset_n,          // Asynchronous reset, active low
    input  wire logic                     soft_reset,       // Soft reset pulse
    input  wire logic                     restart_entry,    // Pulse on entering restart
    input  wire wbm_pkg::wbm_sys_mode_e   sys_mode,         // Current system mode
    input  wire wbm_pkg::wbm_access_s     access,           // Decoded register access
    output logic [7:0]                    rdata,            // Read data of the access
    output logic                          spi_fail,         // Parity failure pulse
    output wbm_pkg::wbm_wdog_cfg_s        wdog_cfg,         // Watchdog configuration
    output logic                          lin_flash_mode,   // Slope control removed
    output logic                          lin_slow_slope_select,       // Low-slope mode
    output logic                          lin_transmit_timeout_enable, // TXD timeout on
    output wbm_pkg::wbm_xcvr_modes_s      xcvr_mode         // Effective transceiver modes
);
    logic [7:0] watchdog_control;
    logic [7:0] bus_control_primary;
    logic [7:0] bus_control_secondary;
    logic [7:0] next_watchdog_control;
    logic [7:0] next_bus_control_primary;
    logic [7:0] next_bus_control_secondary;
    logic [7:0] next_rdata;
    logic       next_spi_fail;

    wire wr_access = access.valid && access.write;
    wire wr_wdog   = wr_access && (access.addr == wbm_pkg::ADDR_WDOG_CTRL);
    wire wr_bus_p  = wr_access && (access.addr == wbm_pkg::ADDR_BUS_CTRL_P);
    wire wr_bus_s  = wr_access && (access.addr == wbm_pkg::ADDR_BUS_CTRL_S);
    wire parity_ok = ~^access.wdata;
    wire low_power = (sys_mode == wbm_pkg::WBM_SYS_STOP) || (sys_mode == wbm_pkg::WBM_SYS_SLEEP);

    // Restart keeps parity slot, bus wake and reset limit bits
    wire [7:0] restart_wdog = {watchdog_control[7], 2'b00,
                               watchdog_control[wbm_pkg::WDOG_BUS_WAKE_BIT],
                               watchdog_control[wbm_pkg::WDOG_MAX3_BIT],
                               wbm_pkg::WDOG_PERIOD_RESTART};

    always_comb begin
        next_watchdog_control      = watchdog_control;
        next_bus_control_primary   = bus_control_primary;
        next_bus_control_secondary = bus_control_secondary;
        next_spi_fail              = 1'b0;
        if (soft_reset) begin
            next_watchdog_control      = wbm_pkg::WDOG_CTRL_RESET;
            next_bus_control_primary   = wbm_pkg::BUS_CTRL_P_RESET;
            next_bus_control_secondary = wbm_pkg::BUS_CTRL_S_RESET;
        end else if (restart_entry) begin
            next_watchdog_control = restart_wdog;
        end else begin
            if (wr_wdog) begin
                if (parity_ok) begin
                    next_watchdog_control = access.wdata & wbm_pkg::WDOG_CTRL_MASK;
                end else begin
                    next_spi_fail = 1'b1;
                end
            end
            if (wr_bus_p) begin
                next_bus_control_primary = access.wdata & wbm_pkg::BUS_CTRL_P_MASK;
            end
            if (wr_bus_s) begin
                next_bus_control_secondary = access.wdata & wbm_pkg::BUS_CTRL_S_MASK;
            end
        end
    end

    // Read returns the value held before this access
    always_comb begin
        next_rdata = 8'h00;
        if (access.valid) begin
            unique case (access.addr)
                wbm_pkg::ADDR_WDOG_CTRL:
                    next_rdata = watchdog_control & wbm_pkg::WDOG_CTRL_MASK;
                wbm_pkg::ADDR_BUS_CTRL_P:
                    next_rdata = bus_control_primary & wbm_pkg::BUS_CTRL_P_MASK;
                wbm_pkg::ADDR_BUS_CTRL_S:
                    next_rdata = bus_control_secondary & wbm_pkg::BUS_CTRL_S_MASK;
                default:
                    next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_control      <= wbm_pkg::WDOG_CTRL_RESET;
            bus_control_primary   <= wbm_pkg::BUS_CTRL_P_RESET;
            bus_control_secondary <= wbm_pkg::BUS_CTRL_S_RESET;
            rdata                 <= 8'h00;
            spi_fail              <= 1'b0;
        end else begin
            watchdog_control      <= next_watchdog_control;
            bus_control_primary   <= next_bus_control_primary;
            bus_control_secondary <= next_bus_control_secondary;
            rdata                 <= next_rdata;
            spi_fail              <= next_spi_fail;
        end
    end

    assign wdog_cfg.stop_disable      = watchdog_control[wbm_pkg::WDOG_STOP_DIS_BIT];
    assign wdog_cfg.window            = watchdog_control[wbm_pkg::WDOG_WINDOW_BIT];
    assign wdog_cfg.start_on_bus_wake = watchdog_control[wbm_pkg::WDOG_BUS_WAKE_BIT];
    assign wdog_cfg.max_three_resets  = watchdog_control[wbm_pkg::WDOG_MAX3_BIT];
    assign wdog_cfg.period_select     = watchdog_control[wbm_pkg::WDOG_PERIOD_LSB +: 3];
    assign wdog_cfg.period_valid      = (watchdog_control[wbm_pkg::WDOG_PERIOD_LSB +: 3]
                                         <= wbm_pkg::WDOG_PERIOD_MAX);

    assign lin_flash_mode              = bus_control_primary[wbm_pkg::LIN_FLASH_BIT];
    assign lin_slow_slope_select       = bus_control_primary[wbm_pkg::LIN_SLOPE_BIT];
    assign lin_transmit_timeout_enable = bus_control_primary[wbm_pkg::LIN_TXTO_BIT];

    // Programmed fields per transceiver: CAN, LIN one, LIN two, LIN three
    wire [7:0] prog_modes = {bus_control_primary[wbm_pkg::MODE_LO_LSB +: 2],
                             bus_control_primary[wbm_pkg::MODE_HI_LSB +: 2],
                             bus_control_secondary[wbm_pkg::MODE_LO_LSB +: 2],
                             bus_control_secondary[wbm_pkg::MODE_HI_LSB +: 2]};
    wire [7:0] eff_modes;

    // Normal falls back to wake capable in low power; register field is untouched
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_xcvr
            wire [1:0] prog = prog_modes[2*g +: 2];
            assign eff_modes[2*g +: 2] =
                (low_power && (prog == wbm_pkg::WBM_XCVR_NORMAL))
                    ? wbm_pkg::WBM_XCVR_WAKE : prog;
        end
    endgenerate

    assign xcvr_mode = eff_modes;
endmodule

//--- logic/wbm_pkg.sv
/*
 Package for the watchdog and bus mode register bank: register addresses, field positions,
 reset values, transceiver and system mode encodings, the register access carrier.
 Assumes an SPI frame decoder outside delivers one decoded byte access at a time.
*/
package wbm_pkg;
    localparam logic [6:0] ADDR_WDOG_CTRL   = 7'h03;
    localparam logic [6:0] ADDR_BUS_CTRL_P  = 7'h04;
    localparam logic [6:0] ADDR_BUS_CTRL_S  = 7'h05;

    localparam logic [7:0] WDOG_CTRL_RESET  = 8'h14;
    localparam logic [7:0] BUS_CTRL_P_RESET = 8'h20;
    localparam logic [7:0] BUS_CTRL_S_RESET = 8'h00;
    localparam logic [2:0] WDOG_PERIOD_RESTART = 3'h4;

    localparam int WDOG_PARITY_BIT   = 7;
    localparam int WDOG_STOP_DIS_BIT = 6;
    localparam int WDOG_WINDOW_BIT   = 5;
    localparam int WDOG_BUS_WAKE_BIT = 4;
    localparam int WDOG_MAX3_BIT     = 3;
    localparam int WDOG_PERIOD_LSB   = 0;
    localparam int LIN_FLASH_BIT     = 7;
    localparam int LIN_SLOPE_BIT     = 6;
    localparam int LIN_TXTO_BIT      = 5;
    localparam int MODE_HI_LSB       = 3;
    localparam int MODE_LO_LSB       = 0;

    // Writable bits of each register; all others read as zero
    localparam logic [7:0] WDOG_CTRL_MASK  = 8'h7F;
    localparam logic [7:0] BUS_CTRL_P_MASK = 8'hFB;
    localparam logic [7:0] BUS_CTRL_S_MASK = 8'h1B;

    // Watchdog period codes; six and seven are reserved
    localparam logic [2:0] WDOG_PERIOD_MAX = 3'h5;
    localparam int WDOG_PERIOD_MS [0:5] = '{10, 20, 50, 100, 200, 500};

    typedef enum logic [1:0] {
        WBM_XCVR_OFF     = 2'b00,
        WBM_XCVR_WAKE    = 2'b01,
        WBM_XCVR_RX_ONLY = 2'b10,
        WBM_XCVR_NORMAL  = 2'b11
    } wbm_xcvr_mode_e;

    typedef enum logic [1:0] {
        WBM_SYS_NORMAL,
        WBM_SYS_SLEEP,
        WBM_SYS_STOP
    } wbm_sys_mode_e;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [6:0] addr;
        logic [7:0] wdata;
    } wbm_access_s;

    typedef struct packed {
        logic       stop_disable;
        logic       window;
        logic       start_on_bus_wake;
        logic       max_three_resets;
        logic [2:0] period_select;
        logic       period_valid;
    } wbm_wdog_cfg_s;

    typedef struct packed {
        logic [1:0] can;
        logic [1:0] lin_one;
        logic [1:0] lin_two;
        logic [1:0] lin_three;
    } wbm_xcvr_modes_s;
endpackage

//--- dv/wbm_regs_checker.sv
/* Port checker for the watchdog and bus mode register bank.
   Assumes one clock domain and the strobe contract of the bank. */
`timescale 1ns/1ns
module wbm_regs_checker (
    input wire logic                     clock,       // Clock
    input wire logic                     reset_n,     // Reset
    input wire logic                     soft_reset,  // Soft reset
    input wire logic                     restart_entry, // Restart
    input wire wbm_pkg::wbm_sys_mode_e   sys_mode,    // System mode
    input wire wbm_pkg::wbm_access_s     access,      // Access
    input wire logic [7:0]               rdata,       // Read data
    input wire logic                     spi_fail,    // Failure pulse
    input wire wbm_pkg::wbm_wdog_cfg_s   wdog_cfg,    // Watchdog setup
    input wire logic                     lin_flash_mode, // Flash
    input wire logic                     lin_slow_slope_select, // Slope
    input wire logic                     lin_transmit_timeout_enable, // Timeout
    input wire wbm_pkg::wbm_xcvr_modes_s xcvr_mode    // Modes
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire wr  = access.valid && access.write && !soft_reset && !restart_entry;
    wire nrm = sys_mode == wbm_pkg::WBM_SYS_NORMAL;
    parity_fail_a: assert property (wr && access.addr == 7'h03 && ^access.wdata |=> spi_fail)
        else $error("odd parity write not flagged");
    wdog_write_a: assert property (wr && access.addr == 7'h03 && !(^access.wdata)
        |=> wdog_cfg[7:1] == $past(access.wdata[6:0]))
        else $error("watchdog fields not loaded");
    parity_read_a: assert property (access.valid && !access.write && access.addr == 7'h03
        |=> !rdata[7])
        else $error("parity bit read as one");
    period_code_a: assert property (wdog_cfg.period_valid == (wdog_cfg.period_select < 3'h6))
        else $error("period validity wrong");
    restart_load_a: assert property (restart_entry && !soft_reset |=> !wdog_cfg.stop_disable
        && !wdog_cfg.window && wdog_cfg.period_select == 3'h4 && $stable(wdog_cfg[5:4]))
        else $error("restart value wrong");
    soft_load_a: assert property (soft_reset |=> wdog_cfg[7:1] == 7'h14 && !lin_flash_mode
        && !lin_slow_slope_select && lin_transmit_timeout_enable)
        else $error("soft reset value wrong");
    bus_write_a: assert property (wr && access.addr == 7'h04 && nrm ##1 nrm
        |-> {lin_flash_mode, lin_slow_slope_select, lin_transmit_timeout_enable, xcvr_mode[7:4]}
        == $past({access.wdata[7:5], access.wdata[1:0], access.wdata[4:3]}))
        else $error("primary bus fields wrong");
    low_power_a: assert property (!nrm |-> xcvr_mode.can != 2'b11 && xcvr_mode.lin_one != 2'b11
        && xcvr_mode.lin_two != 2'b11 && xcvr_mode.lin_three != 2'b11)
        else $error("normal transceiver in low power");
    hold_state_a: assert property (!wr |=> $stable(wdog_cfg) || $past(soft_reset || restart_entry))
        else $error("state changed without write");
    cover property (spi_fail);
    cover property (restart_entry);
    cover property (sys_mode == wbm_pkg::WBM_SYS_STOP && xcvr_mode.can == 2'b01);
endmodule
bind wbm_regs wbm_regs_checker chk (.clock(clock), .reset_n(reset_n), .soft_reset(soft_reset),
    .restart_entry(restart_entry), .sys_mode(sys_mode), .access(access), .rdata(rdata),
    .spi_fail(spi_fail), .wdog_cfg(wdog_cfg), .lin_flash_mode(lin_flash_mode),
    .lin_slow_slope_select(lin_slow_slope_select), .xcvr_mode(xcvr_mode),
    .lin_transmit_timeout_enable(lin_transmit_timeout_enable));

//--- dv/wbm_host.sv
/* Host model issuing decoded register accesses.
   Assumes the bank takes a strobe on a rising edge and answers one cycle later. */
`timescale 1ns/1ns
module wbm_host (
    input  wire logic            clock,    // Clock
    input  wire logic [7:0]      rdata,    // Read data
    input  wire logic            spi_fail, // Failure pulse
    output wbm_pkg::wbm_access_s access    // Request
);
    logic [7:0] last_rd;
    logic       last_fail;
    initial access = '{valid: 1'b0, write: 1'b0, addr: 7'h7F, wdata: 8'hFF};
    // Launch after a falling edge, hold over the taking edge, sample the answer next
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d);
        @(negedge clock);
        access <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
        @(negedge clock);
        last_rd = rdata;
        last_fail = spi_fail;
        // Released bus shows the inverse so stale values never look valid
        access <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
    endtask
endmodule

//--- dv/wbm_regs_bench.sv
/* Self-checking bench for the register bank with a host model.
   Assumes the checker binds itself to the bank. */
`timescale 1ns/1ns
module wbm_regs_bench;
    logic                     clock, reset_n, soft_reset, restart_entry, spi_fail;
    wbm_pkg::wbm_sys_mode_e   sys_mode;
    wbm_pkg::wbm_access_s     access;
    wbm_pkg::wbm_wdog_cfg_s   wdog_cfg;
    wbm_pkg::wbm_xcvr_modes_s xcvr_mode;
    logic [7:0]               rdata, r3, r4, r5, d;
    logic [6:0]               a;
    logic [1:0]               kv, cv;
    int                       n_mismatch = 0, checked = 0;
    wbm_regs dut (.clock(clock), .reset_n(reset_n), .soft_reset(soft_reset),
        .restart_entry(restart_entry), .sys_mode(sys_mode), .access(access), .rdata(rdata),
        .spi_fail(spi_fail), .wdog_cfg(wdog_cfg), .lin_flash_mode(), .lin_slow_slope_select(),
        .lin_transmit_timeout_enable(), .xcvr_mode(xcvr_mode));
    wbm_host host (.clock(clock), .rdata(rdata), .spi_fail(spi_fail), .access(access));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [1:0] eff(input logic [1:0] v);
        return (sys_mode != wbm_pkg::WBM_SYS_NORMAL && v == 2'b11) ? 2'b01 : v;
    endfunction
    task automatic wr(input logic [6:0] wa, input logic [7:0] wd);
        host.xfer(1'b1, wa, wd);
        if (wa == 7'h03 && ^wd) check({7'h00, host.last_fail}, 8'h01);
        else if (wa == 7'h03) r3 = wd & 8'h7F;
        else if (wa == 7'h04) r4 = wd & 8'hFB;
        else if (wa == 7'h05) r5 = wd & 8'h1B;
    endtask
    task automatic rd(input logic [6:0] ra);
        host.xfer(1'b0, ra, 8'($urandom));
        check(host.last_rd, ra == 7'h03 ? r3 : ra == 7'h04 ? r4 : ra == 7'h05 ? r5 : 8'h00);
    endtask
    task automatic close_out;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        #2_000_000;
        n_mismatch++;
        close_out;
    end
    initial begin
        {reset_n, soft_reset, restart_entry} = 3'h0;
        sys_mode = wbm_pkg::WBM_SYS_NORMAL;
        {r3, r4, r5} = 24'h14_2000;
        void'($urandom(32'h4c12));
        repeat (4) @(posedge clock);
        @(negedge clock) reset_n = 1'b1;
        for (int i = 3; i < 7; i++) rd(7'(i));
        $display("reset values done");
        repeat (80) begin
            a = 7'(3 + $urandom_range(3));
            d = 8'($urandom);
            if (a == 7'h03 && $urandom_range(3) != 0) d[7] = ^d[6:0];
            wr(a, d);
            rd(a);
        end
        $display("random access done");
        for (int k = 0; k < 4; k++) begin
            for (int m = 2; m >= 0; m--) begin
                kv = 2'(k);
                cv = (m == 1) ? {1'b0, kv[0]} : kv;
                sys_mode = wbm_pkg::WBM_SYS_NORMAL;
                wr(7'h04, {3'($urandom), kv, 1'b0, cv});
                wr(7'h05, {3'h0, kv, 1'b0, kv});
                @(negedge clock) sys_mode = wbm_pkg::wbm_sys_mode_e'(m);
                @(negedge clock) check(xcvr_mode, {eff(cv), eff(kv), eff(kv), eff(kv)});
            end
        end
        $display("transceiver modes done");
        sys_mode = wbm_pkg::WBM_SYS_NORMAL;
        wr(7'h03, 8'hFF);
        @(negedge clock) restart_entry = 1'b1;
        @(negedge clock) restart_entry = 1'b0;
        r3 = 8'h1C;
        rd(7'h03);
        @(negedge clock) soft_reset = 1'b1;
        @(negedge clock) soft_reset = 1'b0;
        {r3, r4, r5} = 24'h14_2000;
        for (int i = 3; i < 6; i++) rd(7'(i));
        $display("restart and soft reset done");
        close_out;
    end
endmodule
